// *** pkg/pdsr_pkg.sv ***
package pdsr_pkg;
  // register map
  localparam logic [7:0] ADDR_STOP_RECOVERY = 8'h0b;
  localparam logic [7:0] ADDR_PD_STATUS     = 8'h0c;
  localparam logic [7:0] ADDR_PD_CONTROL    = 8'h0d;
  // stop_recovery_config fields
  localparam int         BIT_DIV16    = 0;
  localparam int         BIT_NODIV2   = 1;
  localparam int         BIT_SRC_LO   = 2;
  localparam int         BIT_DELAY_EN = 5;
  localparam int         BIT_WAKE_POL = 6;
  localparam int         BIT_WARM     = 7;
  localparam logic [6:0] SRC_CFG_POR_RESET = 7'h20;
  // opcodes
  localparam logic [7:0] OP_NO_OP = 8'hff;
  localparam logic [7:0] OP_IDLE  = 8'h7f;
  localparam logic [7:0] OP_DEEP  = 8'h6f;
  localparam logic [15:0] RESTART_ADDR = 16'h000c;
  // wake source codes
  localparam logic [2:0] SRC_RESET_ONLY = 3'h0;
  localparam logic [2:0] SRC_P30        = 3'h1;
  localparam logic [2:0] SRC_P31        = 3'h2;
  localparam logic [2:0] SRC_P32        = 3'h3;
  localparam logic [2:0] SRC_P33        = 3'h4;
  localparam logic [2:0] SRC_P27        = 3'h5;
  localparam logic [2:0] SRC_NOR_LO     = 3'h6;
  localparam logic [2:0] SRC_NOR_ALL    = 3'h7;
  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RESET_DELAY_NS  = 20000;
  localparam int RESET_DELAY_CYC =
    (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEEP_WDT_NS     = 40000;
  localparam int DEEP_WDT_CYC    = DEEP_WDT_NS / CLK_PERIOD_NS;
  localparam int WAKE_MIN_TPC    = 5;

  typedef enum logic [1:0] {PDSR_RUN, PDSR_IDLE, PDSR_DEEP, PDSR_WAKE}
    pdsr_mode_e;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pdsr_req_s;

  // wake pins
  typedef struct packed {
    logic [7:0] port2;
    logic [3:0] port3;
  } pdsr_pins_s;
endpackage

// *** logic/pdsr_top.sv ***
// Notes on behaviour
// - idle gates cpu clock, timer keeps running
// - opcode 7f after ff enters idle
// - any interrupt ends idle, resume next
// - reset or watchdog ends idle, restart 000c
// - divider bits rewritable during idle, immediate
// - deep mode stops oscillator and system clock
// - opcode 6f after ff enters deep
// - deep exits only via reset, restart 000c
// - enabled watchdog resets after fixed deep time
// - simple variant: low port2_bit7 wakes
// - wake reset loads alternate register values
// - config at 0b, bit 7 read only
// - bit 0 inserts divide by 16
// - bit 1 selects divide by two or not
// - bits 4:2 select wake source
// - bit 5 inserts reset delay, resets 1
// - bit 6 wake polarity, cleared at reset
// - bit 7 cold zero, warm one
`timescale 1ns/10ps
`default_nettype none
module pdsr_top #(
  parameter int RESET_DELAY_CYC = pdsr_pkg::RESET_DELAY_CYC,
  parameter int DEEP_WDT_CYC    = pdsr_pkg::DEEP_WDT_CYC,
  parameter bit SIMPLE_WAKE     = 1'b0
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire pdsr_pkg::pdsr_req_s reg_req,
  output logic [7:0]             reg_rdata,
  input  wire logic [7:0]        opcode,
  input  wire logic              opcode_valid,
  input  wire logic              irq_any,
  input  wire logic              reset_pin_n,
  input  wire logic              wdt_timeout,
  input  wire pdsr_pkg::pdsr_pins_s wake_pins,
  output logic                   cpu_clk_en,
  output logic                   timer_clk_en,
  output logic                   osc_run,
  output logic                   core_reset,
  output logic [15:0]            restart_addr,
  output logic                   resume_next,
  output logic                   alt_reset_vals
);
  // ==========================================================
  // registers
  pdsr_pkg::pdsr_mode_e mode_q;
  logic [6:0]  cfg_q;
  logic        warm_q;
  logic        deep_wdt_en_q;
  logic        prev_nop_q;
  logic [15:0] delay_cnt_q;
  logic [31:0] wdt_cnt_q;
  logic [4:0]  div_cnt_q;
  logic [2:0]  wake_run_q;
  logic        alt_q;
  logic        ext_reset;
  logic        wake_lvl;
  logic        wake_raw;
  logic        tick;
  logic        enter_idle;
  logic        enter_deep;
  logic        wdt_fire;

  assign ext_reset = !reset_pin_n || wdt_timeout;
  assign enter_idle = opcode_valid && opcode == pdsr_pkg::OP_IDLE
                      && prev_nop_q && mode_q == pdsr_pkg::PDSR_RUN;
  assign enter_deep = opcode_valid && opcode == pdsr_pkg::OP_DEEP
                      && prev_nop_q && mode_q == pdsr_pkg::PDSR_RUN;

  // ==========================================================
  // wake source select
  // source decode
  always_comb begin
    case (cfg_q[4:2])
      pdsr_pkg::SRC_P30:     wake_raw = wake_pins.port3[0];
      pdsr_pkg::SRC_P31:     wake_raw = wake_pins.port3[1];
      pdsr_pkg::SRC_P32:     wake_raw = wake_pins.port3[2];
      pdsr_pkg::SRC_P33:     wake_raw = wake_pins.port3[3];
      pdsr_pkg::SRC_P27:     wake_raw = wake_pins.port2[7];
      pdsr_pkg::SRC_NOR_LO:  wake_raw = ~|wake_pins.port2[3:0];
      pdsr_pkg::SRC_NOR_ALL: wake_raw = ~|wake_pins.port2;
      default:               wake_raw = 1'b0;
    endcase
  end
  always_comb begin
    if (SIMPLE_WAKE) begin
      wake_lvl = !wake_pins.port2[7];
    end else if (cfg_q[4:2] == pdsr_pkg::SRC_RESET_ONLY) begin
      wake_lvl = 1'b0;
    end else begin
      wake_lvl = cfg_q[pdsr_pkg::BIT_WAKE_POL] ? wake_raw : !wake_raw;
    end
  end

  // ==========================================================
  // no_op tracker
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_nop_q <= 1'b0;
    end else if (opcode_valid) begin
      prev_nop_q <= opcode == pdsr_pkg::OP_NO_OP;
    end
  end

  // ==========================================================
  // wake qualification count
  // fast wake needs five clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_run_q <= 3'h0;
    end else if (mode_q != pdsr_pkg::PDSR_DEEP || !wake_lvl) begin
      wake_run_q <= 3'h0;
    end else if (wake_run_q != 3'(pdsr_pkg::WAKE_MIN_TPC)) begin
      wake_run_q <= wake_run_q + 3'h1;
    end
  end

  // deep watchdog counter
  // fixed time after entry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_q <= 32'h0;
    end else if (mode_q != pdsr_pkg::PDSR_DEEP) begin
      wdt_cnt_q <= 32'h0;
    end else if (deep_wdt_en_q) begin
      wdt_cnt_q <= wdt_cnt_q + 32'h1;
    end
  end
  assign wdt_fire = deep_wdt_en_q && mode_q == pdsr_pkg::PDSR_DEEP
                    && wdt_cnt_q == 32'(DEEP_WDT_CYC - 1);

  // ==========================================================
  // mode machine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q      <= pdsr_pkg::PDSR_RUN;
      delay_cnt_q <= 16'h0;
      warm_q      <= 1'b0;
      alt_q       <= 1'b0;
    end else begin
      case (mode_q)
        pdsr_pkg::PDSR_RUN: begin
          if (ext_reset) begin
            warm_q <= 1'b0;
            alt_q  <= 1'b0;
          end else if (enter_idle) begin
            mode_q <= pdsr_pkg::PDSR_IDLE;
          end else if (enter_deep) begin
            mode_q <= pdsr_pkg::PDSR_DEEP;
          end
        end
        pdsr_pkg::PDSR_IDLE: begin
          if (ext_reset) begin
            mode_q <= pdsr_pkg::PDSR_RUN;
            warm_q <= 1'b0;
            alt_q  <= 1'b0;
          end else if (irq_any) begin
            mode_q <= pdsr_pkg::PDSR_RUN;
          end
        end
        pdsr_pkg::PDSR_DEEP: begin
          if (!reset_pin_n) begin
            mode_q <= pdsr_pkg::PDSR_RUN;
            warm_q <= 1'b0;
            alt_q  <= 1'b0;
          end else if (wdt_fire || wdt_timeout) begin
            mode_q <= pdsr_pkg::PDSR_RUN;
            warm_q <= 1'b0;
            alt_q  <= 1'b1;
          end else if (wake_run_q == 3'(pdsr_pkg::WAKE_MIN_TPC)) begin
            warm_q <= 1'b1;
            alt_q  <= 1'b1;
            if (cfg_q[pdsr_pkg::BIT_DELAY_EN]) begin
              mode_q      <= pdsr_pkg::PDSR_WAKE;
              delay_cnt_q <= 16'(RESET_DELAY_CYC - 1);
            end else begin
              mode_q <= pdsr_pkg::PDSR_RUN;
            end
          end
        end
        pdsr_pkg::PDSR_WAKE: begin
          if (delay_cnt_q == 16'h0) begin
            mode_q <= pdsr_pkg::PDSR_RUN;
          end else begin
            delay_cnt_q <= delay_cnt_q - 16'h1;
          end
        end
        default: mode_q <= pdsr_pkg::PDSR_RUN;
      endcase
    end
  end

  // ==========================================================
  // config register writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q         <= pdsr_pkg::SRC_CFG_POR_RESET;
      deep_wdt_en_q <= 1'b0;
    end else if (mode_q == pdsr_pkg::PDSR_DEEP
                 && wake_run_q == 3'(pdsr_pkg::WAKE_MIN_TPC)
                 && reset_pin_n && !wdt_timeout && !wdt_fire) begin
      // wake reset keeps source setup, divider defaults
      cfg_q[1:0] <= 2'h0;
    end else if (reg_req.wr) begin
      // divider bits take effect at once, even in idle
      if (reg_req.addr == pdsr_pkg::ADDR_STOP_RECOVERY) begin
        cfg_q <= reg_req.wdata[6:0];
      end
      if (reg_req.addr == pdsr_pkg::ADDR_PD_CONTROL) begin
        deep_wdt_en_q <= reg_req.wdata[0];
      end
    end
  end

  // read port: config bits 6:0 write only, bit 7 gives warm flag, other bits read zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        pdsr_pkg::ADDR_STOP_RECOVERY: reg_rdata <= {warm_q, 7'h00};
        pdsr_pkg::ADDR_PD_STATUS:     reg_rdata <= {6'h00, mode_q};
        pdsr_pkg::ADDR_PD_CONTROL:    reg_rdata <= {7'h00, deep_wdt_en_q};
        default:                      reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // clock divider ticks
  // divide by 16, divide by two
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 5'h00;
    end else if (mode_q == pdsr_pkg::PDSR_DEEP) begin
      div_cnt_q <= 5'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 5'h01;
    end
  end
  // divide by two then by 16 when both apply
  always_comb begin
    case (cfg_q[1:0])
      2'h0:    tick = div_cnt_q[0] == 1'b1;
      2'h2:    tick = 1'b1;
      2'h1:    tick = div_cnt_q == 5'h1f;
      default: tick = div_cnt_q[3:0] == 4'hf;
    endcase
  end
  // enables change only at edges, so no runt pulses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en   <= 1'b0;
      timer_clk_en <= 1'b0;
      osc_run      <= 1'b1;
    end else begin
      cpu_clk_en   <= tick && mode_q == pdsr_pkg::PDSR_RUN;
      timer_clk_en <= tick && (mode_q == pdsr_pkg::PDSR_RUN
                               || mode_q == pdsr_pkg::PDSR_IDLE);
      osc_run      <= mode_q != pdsr_pkg::PDSR_DEEP;
    end
  end

  // ==========================================================
  // core restart outputs
  // restart vector
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reset     <= 1'b1;
      restart_addr   <= pdsr_pkg::RESTART_ADDR;
      resume_next    <= 1'b0;
      alt_reset_vals <= 1'b0;
    end else begin
      core_reset     <= mode_q == pdsr_pkg::PDSR_WAKE || ext_reset
                        || mode_q == pdsr_pkg::PDSR_DEEP;
      restart_addr   <= pdsr_pkg::RESTART_ADDR;
      resume_next    <= mode_q == pdsr_pkg::PDSR_IDLE && irq_any
                        && !ext_reset;
      alt_reset_vals <= alt_q;
    end
  end

  // ==========================================================
  // checks
  property p_idle_gate;
    @(posedge sys_clk) disable iff (!rst_n)
    mode_q == pdsr_pkg::PDSR_IDLE |=> !cpu_clk_en;
  endproperty
  a_idle_gate: assert property (p_idle_gate)
    else $error("cpu clock ran in idle");
  property p_idle_entry;
    @(posedge sys_clk) disable iff (!rst_n)
    enter_idle |=> mode_q == pdsr_pkg::PDSR_IDLE;
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("idle not entered");
  property p_irq_wake;
    @(posedge sys_clk) disable iff (!rst_n)
    mode_q == pdsr_pkg::PDSR_IDLE && irq_any && !ext_reset
      |=> mode_q == pdsr_pkg::PDSR_RUN && resume_next;
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("interrupt did not end idle");
  property p_deep_entry;
    @(posedge sys_clk) disable iff (!rst_n)
    enter_deep |=> mode_q == pdsr_pkg::PDSR_DEEP ##1 !osc_run;
  endproperty
  a_deep_entry: assert property (p_deep_entry)
    else $error("deep mode not entered");
  property p_deep_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    mode_q == pdsr_pkg::PDSR_DEEP && !wake_lvl && !wdt_fire
      && !ext_reset |=> mode_q == pdsr_pkg::PDSR_DEEP;
  endproperty
  a_deep_hold: assert property (p_deep_hold)
    else $error("left deep without reset");
  sequence s_fast_wake;
    mode_q == pdsr_pkg::PDSR_DEEP && reset_pin_n && !wdt_timeout
      && !wdt_fire && wake_run_q == 3'(pdsr_pkg::WAKE_MIN_TPC);
  endsequence
  property p_warm;
    @(posedge sys_clk) disable iff (!rst_n)
    s_fast_wake |=> warm_q ##1 alt_reset_vals;
  endproperty
  a_warm: assert property (p_warm)
    else $error("warm flag not set on wake");
  property p_delay;
    @(posedge sys_clk) disable iff (!rst_n)
    s_fast_wake and cfg_q[pdsr_pkg::BIT_DELAY_EN]
      |=> mode_q == pdsr_pkg::PDSR_WAKE ##1 core_reset;
  endproperty
  a_delay: assert property (p_delay)
    else $error("reset delay skipped");
  property p_nodiv;
    @(posedge sys_clk) disable iff (!rst_n)
    cfg_q[1:0] == 2'h2 && mode_q == pdsr_pkg::PDSR_RUN
      ##1 cfg_q[1:0] == 2'h2 && mode_q == pdsr_pkg::PDSR_RUN
      |=> cpu_clk_en;
  endproperty
  a_nodiv: assert property (p_nodiv)
    else $error("undivided clock missed a tick");
endmodule
`default_nettype wire

// *** tb/pdsr_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// wake pins, reset pin and watchdog source
module pdsr_far_model (
  input  wire logic                 sys_clk,
  output var pdsr_pkg::pdsr_pins_s  wake_pins,
  output logic                      reset_pin_n,
  output logic                      wdt_timeout
);
  // pins idle high, plain digital levels
  // digital pin levels
  initial begin
    wake_pins   = '{port2: 8'hff, port3: 4'hf};
    reset_pin_n = 1'b1;
    wdt_timeout = 1'b0;
  end

  // low level on port2_bit7 for n cycles
  // wake pulse width
  task automatic pulse_p27(input int n);
    @(posedge sys_clk) wake_pins.port2[7] <= 1'b0;
    repeat (n) @(posedge sys_clk);
    wake_pins.port2[7] <= 1'b1;
  endtask

  // one cycle reset pin pulse
  task automatic pin_rst();
    @(posedge sys_clk) reset_pin_n <= 1'b0;
    @(posedge sys_clk) reset_pin_n <= 1'b1;
  endtask

  // one cycle watchdog timeout
  task automatic dog();
    @(posedge sys_clk) wdt_timeout <= 1'b1;
    @(posedge sys_clk) wdt_timeout <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int DLY = 8;
  localparam int WDT = 16;
  logic                 sys_clk = 1'b0;
  logic                 rst_n = 1'b0;
  pdsr_pkg::pdsr_req_s  req = '0;
  logic [7:0]           rdata;
  logic [7:0]           opcode = 8'h00;
  logic                 opcode_valid = 1'b0;
  logic                 irq_any = 1'b0;
  pdsr_pkg::pdsr_pins_s pins;
  logic                 pin_n, dog_to, cpu_en, tmr_en, osc, crst;
  logic [15:0]          raddr;
  logic                 resume, alt;
  int                   n_errors = 0;
  int                   comparisons = 0;
  logic [7:0]           rv;
  logic [15:0]          cc, tc;

  // ==========================================
  // clock and instances
  always #5 sys_clk = ~sys_clk;

  pdsr_far_model FAR (.sys_clk(sys_clk), .wake_pins(pins),
    .reset_pin_n(pin_n), .wdt_timeout(dog_to));

  pdsr_top #(.RESET_DELAY_CYC(DLY), .DEEP_WDT_CYC(WDT),
    .SIMPLE_WAKE(1'b0)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
    .opcode(opcode), .opcode_valid(opcode_valid), .irq_any(irq_any),
    .reset_pin_n(pin_n), .wdt_timeout(dog_to), .wake_pins(pins),
    .cpu_clk_en(cpu_en), .timer_clk_en(tmr_en), .osc_run(osc),
    .core_reset(crst), .restart_addr(raddr), .resume_next(resume),
    .alt_reset_vals(alt));

  // ==========================================
  // verdict and compares
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // ==========================================
  // bus, opcode and wait helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk) req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic enter(input logic [7:0] op);
    @(posedge sys_clk) begin
      opcode <= pdsr_pkg::OP_NO_OP;
      opcode_valid <= 1'b1;
    end
    @(posedge sys_clk) opcode <= op;
    @(posedge sys_clk) opcode_valid <= 1'b0;
  endtask

  task automatic count(input int n);
    cc = '0;
    tc = '0;
    repeat (n) begin
      @(posedge sys_clk) #1;
      cc += 16'(cpu_en === 1'b1);
      tc += 16'(tmr_en === 1'b1);
    end
  endtask

  task automatic wait_osc(input logic lvl, input int lim, output int el);
    el = 0;
    while (osc !== lvl) begin
      @(posedge sys_clk) #1 el++;
      if (el > lim) begin
        n_errors++;
        $display("[ERR] %0t oscillator wait ran out", $time);
        print_verdict();
      end
    end
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs();
    rd(pdsr_pkg::ADDR_STOP_RECOVERY, rv);
    chk_v(16'(rv), 16'h0000);
    wr(pdsr_pkg::ADDR_STOP_RECOVERY, 8'h80);
    rd(pdsr_pkg::ADDR_STOP_RECOVERY, rv);
    chk_v(16'(rv), 16'h0000);
    rd(8'h3a, rv);
    chk_v(16'(rv), 16'h0000);
    chk_v(raddr, pdsr_pkg::RESTART_ADDR);
    count(20);
    chk_v(tc, 16'd10);
    wr(pdsr_pkg::ADDR_STOP_RECOVERY, 8'h22);
    count(10);
    chk_v(cc, 16'd10);
    wr(pdsr_pkg::ADDR_STOP_RECOVERY, 8'h00);
    enter(8'h00);
    @(posedge sys_clk) begin
      opcode <= pdsr_pkg::OP_IDLE;
      opcode_valid <= 1'b1;
    end
    @(posedge sys_clk) opcode_valid <= 1'b0;
    count(20);
    chk_b(cc != 16'd0, 1'b1);
  endtask

  task automatic t_idle();
    int i;
    enter(pdsr_pkg::OP_IDLE);
    repeat (3) @(posedge sys_clk);
    count(20);
    chk_v(cc, 16'd0);
    chk_v(tc, 16'd10);
    wr(pdsr_pkg::ADDR_STOP_RECOVERY, 8'h22);
    repeat (3) @(posedge sys_clk);
    count(10);
    chk_v(tc, 16'd10);
    wr(pdsr_pkg::ADDR_STOP_RECOVERY, 8'h23);
    repeat (20) @(posedge sys_clk);
    count(64);
    chk_v(tc, 16'd4);
    wr(pdsr_pkg::ADDR_STOP_RECOVERY, 8'h21);
    repeat (3) @(posedge sys_clk);
    count(64);
    chk_v(tc, 16'd2);
    @(posedge sys_clk) irq_any <= 1'b1;
    i = 0;
    while (resume !== 1'b1 && i < 10) begin
      @(posedge sys_clk) #1 i++;
    end
    chk_b(resume, 1'b1);
    @(posedge sys_clk) irq_any <= 1'b0;
    count(40);
    chk_b(cc != 16'd0, 1'b1);
    enter(pdsr_pkg::OP_IDLE);
    FAR.dog();
    #1;
    i = 0;
    while (crst !== 1'b1 && i < 10) begin
      @(posedge sys_clk) #1 i++;
    end
    chk_b(crst, 1'b1);
    chk_v(raddr, pdsr_pkg::RESTART_ADDR);
    repeat (DLY + 20) @(posedge sys_clk);
    rd(pdsr_pkg::ADDR_STOP_RECOVERY, rv);
    chk_v(16'(rv), 16'h0000);
  endtask

  task automatic t_deep_pin();
    int el;
    wr(pdsr_pkg::ADDR_STOP_RECOVERY, {3'b000, pdsr_pkg::SRC_P27, 2'b00});
    enter(pdsr_pkg::OP_DEEP);
    wait_osc(1'b0, 10, el);
    chk_b(cpu_en | tmr_en, 1'b0);
    FAR.pulse_p27(3);
    repeat (10) @(posedge sys_clk);
    #1 chk_b(osc, 1'b0);
    FAR.pulse_p27(6);
    wait_osc(1'b1, 20, el);
    chk_v(raddr, pdsr_pkg::RESTART_ADDR);
    repeat (4) @(posedge sys_clk);
    #1 chk_b(alt, 1'b1);
    rd(pdsr_pkg::ADDR_STOP_RECOVERY, rv);
    chk_v(16'(rv), 16'h0080);
  endtask

  task automatic t_deep_rst();
    int el;
    wr(pdsr_pkg::ADDR_STOP_RECOVERY, 8'h20);
    enter(pdsr_pkg::OP_DEEP);
    wait_osc(1'b0, 10, el);
    FAR.pulse_p27(6);
    repeat (4) @(posedge sys_clk);
    #1 chk_b(osc, 1'b0);
    FAR.pin_rst();
    wait_osc(1'b1, 10, el);
    chk_b(alt, 1'b0);
    rd(pdsr_pkg::ADDR_STOP_RECOVERY, rv);
    chk_v(16'(rv), 16'h0000);
    wr(pdsr_pkg::ADDR_STOP_RECOVERY, 8'h34);
    enter(pdsr_pkg::OP_DEEP);
    wait_osc(1'b0, 10, el);
    FAR.pulse_p27(6);
    wait_osc(1'b1, 10, el);
    chk_b(crst, 1'b1);
    repeat (DLY - 1) @(posedge sys_clk);
    #1 chk_b(crst, 1'b1);
    @(posedge sys_clk) #1 chk_b(crst, 1'b0);
    rd(pdsr_pkg::ADDR_STOP_RECOVERY, rv);
    chk_v(16'(rv), 16'h0080);
  endtask

  task automatic t_deep_dog();
    int el;
    wr(pdsr_pkg::ADDR_STOP_RECOVERY, 8'h20);
    wr(pdsr_pkg::ADDR_PD_CONTROL, 8'h01);
    enter(pdsr_pkg::OP_DEEP);
    wait_osc(1'b0, 10, el);
    wait_osc(1'b1, WDT + 40, el);
    chk_b(el >= WDT - 1, 1'b1);
    repeat (DLY + 10) @(posedge sys_clk);
    #1 chk_b(alt, 1'b1);
    rd(pdsr_pkg::ADDR_STOP_RECOVERY, rv);
    chk_v(16'(rv), 16'h0000);
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (DLY + 20) @(posedge sys_clk);
    t_regs();
    t_idle();
    t_deep_pin();
    t_deep_rst();
    t_deep_dog();
    print_verdict();
  end
endmodule
`default_nettype wire
